// ===== design/lossl_top.sv
// Line loss-of-signal status logic: digital and analog detectors, status and interrupt
// ==========================================================
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module lossl_top
  import lossl_pkg::*;
(
  input wire logic i_sys_clk, // 40 MHz system clock
  input wire logic i_sys_rst, // Synchronous reset, active high
  input wire logic i_bit_tick, // Pin: high marks one received bit period
  input wire logic i_pulse, // Pin: a pulse seen in that bit period
  input wire logic i_amp_low, // Pin: amplitude below declare threshold
  input wire logic i_amp_ok, // Pin: amplitude above clear threshold
  input wire logic i_g775_los, // Pin: E3 detector declares
  input wire logic [LOSSL_AW-1:0] i_addr, // Register address
  input wire logic [LOSSL_DW-1:0] i_wdata, // Register write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [LOSSL_DW-1:0] o_rdata, // Read data, cycle after strobe
  output logic o_los, // Channel loss of signal
  output logic o_irq // Interrupt, level
);
  // ==========================================================
  // Input synchronisers
  logic [3:0] pin_m_r; // First stage, read only by second stage
  logic [3:0] pin_s_r; // Second stage
  logic g775_m_r; // First stage of E3 detector pin
  logic g775_s_r; // Second stage
  logic tick; // Synced bit period strobe
  logic pulse; // Synced pulse flag
  logic amp_low; // Synced low amplitude flag
  logic amp_ok; // Synced good amplitude flag

  // Pins come from the line side with no timing relation to this clock
  // Two flops on every pin, the trade is two cycles of latency
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pin_m_r <= 4'h0;
      pin_s_r <= 4'h0;
      g775_m_r <= 1'b0;
      g775_s_r <= 1'b0;
    end else begin
      pin_m_r <= {i_amp_ok, i_amp_low, i_pulse, i_bit_tick};
      pin_s_r <= pin_m_r;
      g775_m_r <= i_g775_los;
      g775_s_r <= g775_m_r;
    end
  end

  assign tick = pin_s_r[0];
  assign pulse = pin_s_r[1];
  assign amp_low = pin_s_r[2];
  assign amp_ok = pin_s_r[3];

  // ==========================================================
  // Address decode
  // One shared compare, so the write and read paths can never disagree on the map
  function automatic logic addr_hit(input logic [LOSSL_AW-1:0] a, input logic [LOSSL_AW-1:0] off);
    return a == off;
  endfunction

  // ==========================================================
  // Control register
  logic [LOSSL_DW-1:0] ctrl_r; // Mode control
  logic e3; // E3 operation selected

  // Software selects the line mode
  // Only bit 0 acts; the spare bits are kept so software reads back what it wrote
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= LOSSL_RST_CTRL;
    end else if (i_wr && addr_hit(i_addr, LOSSL_OFF_CTRL)) begin
      ctrl_r <= i_wdata;
    end
  end

  assign e3 = ctrl_r[LOSSL_CTRL_E3];

  // ==========================================================
  // Pulse-free run counter
  logic [7:0] zero_cnt_r; // Consecutive periods with no pulse
  logic dig_set; // Digital declare condition

  // Saturates at the declare count so a long outage cannot wrap
  // A single pulse restarts the run, so a sparse but live line never declares
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || e3) begin
      zero_cnt_r <= 8'h00;
    end else if (tick) begin
      if (pulse) begin
        zero_cnt_r <= 8'h00;
      end else if (zero_cnt_r < 8'(LOSSL_ZERO_RUN)) begin
        zero_cnt_r <= zero_cnt_r + 8'h01;
      end
    end
  end

  assign dig_set = tick && !pulse && zero_cnt_r == 8'(LOSSL_ZERO_RUN - 1) && !e3;

  // ==========================================================
  // Density window
  logic [LOSSL_WIN_AW-1:0] wptr_r; // Oldest slot, overwritten next
  logic full_r; // Window holds a full set of samples
  logic upd_r; // Sample written last cycle
  logic new_r; // That sample's pulse flag
  logic old_vld_r; // Slot read last cycle held a real sample
  logic old_bit; // Sample leaving the window
  logic [6:0] dens_r; // Pulses inside the window

  lossl_win_mem u_win (
    .i_sys_clk(i_sys_clk),
    .i_we(tick),
    .i_addr(wptr_r),
    .i_wdata(pulse),
    .o_rdata(old_bit)
  );

  // Window length is our choice; 64 slots keep the count within 7 bits
  // Pointer and fill state; unfilled slots count as no pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wptr_r <= '0;
      full_r <= 1'b0;
      upd_r <= 1'b0;
      new_r <= 1'b0;
      old_vld_r <= 1'b0;
    end else begin
      upd_r <= tick;
      new_r <= pulse;
      old_vld_r <= full_r;
      if (tick) begin
        wptr_r <= wptr_r + 1'b1;
        if (wptr_r == LOSSL_WIN_AW'(LOSSL_WIN - 1)) begin
          full_r <= 1'b1;
        end
      end
    end
  end

  // Sliding count: add the newest, drop the oldest
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      dens_r <= 7'h00;
    end else if (upd_r) begin
      dens_r <= dens_r + {6'h00, new_r} - {6'h00, old_vld_r & old_bit};
    end
  end

  // ==========================================================
  // Detectors
  logic dig_r; // Digital detector declares
  logic ana_r; // Analog detector declares
  logic dens_ok; // Density at or above the clear level

  assign dens_ok = dens_r >= 7'(LOSSL_DENS_MIN);

  // Digital detector; declare outranks clear
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || e3) begin
      dig_r <= 1'b0;
    end else if (dig_set) begin
      dig_r <= 1'b1;
    end else if (dens_ok) begin
      dig_r <= 1'b0;
    end
  end

  // Both flags at once cannot happen on a real line; declare is given priority
  // Analog flag; between thresholds it holds, giving hysteresis
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || e3) begin
      ana_r <= 1'b0;
    end else if (amp_low) begin
      ana_r <= 1'b1;
    end else if (amp_ok) begin
      ana_r <= 1'b0;
    end
  end

  // ==========================================================
  // Channel state
  logic los_r; // Channel loss of signal

  // Registered so o_los comes straight from a flop, at the cost of one cycle
  // E3 bypasses both detectors
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      los_r <= 1'b0;
    end else if (e3) begin
      los_r <= g775_s_r;
    end else begin
      los_r <= dig_r | ana_r;
    end
  end

  assign o_los = los_r;

  // ==========================================================
  // Events and interrupt
  logic [2:0] prev_r; // Last detector states, for edges
  logic [2:0] rise; // Declare edges
  logic [LOSSL_DW-1:0] evt_r; // Sticky events
  logic [LOSSL_DW-1:0] mask_r; // Interrupt enables
  logic [LOSSL_DW-1:0] evt_clr; // Bits software clears
  logic irq_r; // Interrupt flop

  // Events are edges, so a state that stays up sets its bit only once
  assign rise = {los_r, ana_r, dig_r} & ~prev_r;
  assign evt_clr = (i_wr && addr_hit(i_addr, LOSSL_OFF_EVENT)) ? i_wdata : 8'h00;

  // Edge history
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      prev_r <= 3'h0;
    end else begin
      prev_r <= {los_r, ana_r, dig_r};
    end
  end

  // A new event in the clearing cycle is kept
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      evt_r <= LOSSL_RST_EVENT;
    end else begin
      evt_r <= (evt_r & ~evt_clr) | {5'h00, rise};
    end
  end

  // Mask register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mask_r <= LOSSL_RST_MASK;
    end else if (i_wr && addr_hit(i_addr, LOSSL_OFF_MASK)) begin
      mask_r <= i_wdata;
    end
  end

  // Interrupt follows one cycle behind the masked sticky events
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_r & mask_r);
    end
  end

  assign o_irq = irq_r;

  // ==========================================================
  // Read port
  logic [LOSSL_DW-1:0] alarm; // Alarm status image
  logic [LOSSL_DW-1:0] rdata_r; // Read data flop

  // Other alarm bits belong to blocks outside this one and read zero
  always_comb begin
    alarm = 8'h00;
    alarm[LOSSL_BIT_DIG] = dig_r;
    alarm[LOSSL_BIT_ANA] = ana_r;
    alarm[LOSSL_BIT_LOS] = los_r;
  end

  // Zero outside the answer cycle, so several slaves can share a wired-OR bus
  // Alarm has no write path at all; unmapped reads give zero
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !i_rd) begin
      rdata_r <= 8'h00;
    end else if (addr_hit(i_addr, LOSSL_OFF_ALARM)) begin
      rdata_r <= alarm;
    end else if (addr_hit(i_addr, LOSSL_OFF_EVENT)) begin
      rdata_r <= evt_r;
    end else if (addr_hit(i_addr, LOSSL_OFF_MASK)) begin
      rdata_r <= mask_r;
    end else if (addr_hit(i_addr, LOSSL_OFF_CTRL)) begin
      rdata_r <= ctrl_r;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign o_rdata = rdata_r;

  // ==========================================================
  // Assertions
  // All checks run on the system clock and sleep while reset is high
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_dig_declare: assert property (dig_set |=> dig_r)
    else $error("digital detector missed declare");
  a_dig_early: assert property (!dig_r && $past(!dig_r) && !dig_set |=> !dig_r)
    else $error("digital detector declared without run");
  a_dig_clear: assert property (dig_r && dens_ok && !dig_set && !e3 |=> !dig_r)
    else $error("digital detector missed clear");
  a_dig_hold: assert property (dig_r && !dens_ok && !e3 |=> dig_r)
    else $error("digital detector cleared at low density");
  a_ana_set: assert property (amp_low && !e3 |=> ana_r)
    else $error("analog flag missed declare");
  a_ana_hyst: assert property (ana_r && !amp_ok && !e3 |=> ana_r)
    else $error("analog flag cleared between thresholds");
  a_los_or: assert property (!e3 ##1 !e3 |-> los_r == $past(dig_r | ana_r))
    else $error("channel state not OR of detectors");
  a_los_e3: assert property (e3 ##1 e3 |-> los_r == $past(g775_s_r))
    else $error("E3 channel state wrong");
  a_alarm_read: assert property (i_rd && i_addr == LOSSL_OFF_ALARM |=>
      o_rdata == {2'b00, $past(dig_r), $past(ana_r), 2'b00, $past(los_r), 1'b0})
    else $error("alarm read image wrong");
  a_bit5_read: assert property (i_rd && i_addr == LOSSL_OFF_ALARM && dig_r |=> o_rdata[5])
    else $error("bit 5 lost digital state");
  a_bit4_read: assert property (i_rd && i_addr == LOSSL_OFF_ALARM && !ana_r |=> !o_rdata[4])
    else $error("bit 4 shows false analog state");

  // Counters stay in range, and each state follows its own cause
  a_zero_sat: assert property (zero_cnt_r <= 8'(LOSSL_ZERO_RUN))
    else $error("pulse-free run counter passed its ceiling");
  a_zero_restart: assert property (tick && pulse && !e3 |=> zero_cnt_r == 8'h00)
    else $error("pulse did not restart the run");
  a_dens_range: assert property (dens_r <= 7'(LOSSL_WIN))
    else $error("density count exceeds window length");
  a_ana_clear: assert property (ana_r && amp_ok && !amp_low && !e3 |=> !ana_r)
    else $error("analog flag missed clear");
  a_los_follow: assert property ((dig_r || ana_r) && !e3 |=> o_los)
    else $error("channel state missed a detector");
  a_e3_idle: assert property (e3 |=> !dig_r && !ana_r)
    else $error("line detectors active in E3 mode");
  a_bit1_read: assert property (i_rd && i_addr == LOSSL_OFF_ALARM |=> o_rdata[LOSSL_BIT_LOS] == $past(los_r))
    else $error("bit 1 does not show channel state");

  // Scenarios worth seeing at least once
  c_dig_cycle: cover property (dig_r ##[1:1000] !dig_r);
  c_ana_cycle: cover property (ana_r ##[1:100] !ana_r);
  c_irq: cover property (rise[LOSSL_EV_LOS] ##[1:4] o_irq);
  c_e3_los: cover property (e3 && los_r);
  c_dens_clear: cover property (dig_r && dens_ok);
endmodule

// ===== design/lossl_pkg.sv
// Constants shared by the line loss-of-signal status block
package lossl_pkg;
  // ==========================================================
  // Register bus geometry
  localparam int unsigned LOSSL_AW = 8;
  localparam int unsigned LOSSL_DW = 8;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] LOSSL_OFF_ALARM = 8'h00; // Alarm status, read only
  localparam logic [7:0] LOSSL_OFF_EVENT = 8'h04; // Sticky events, write one to clear
  localparam logic [7:0] LOSSL_OFF_MASK = 8'h08; // Interrupt enables
  localparam logic [7:0] LOSSL_OFF_CTRL = 8'h0C; // Line mode control
  // ==========================================================
  // Field positions
  localparam int unsigned LOSSL_BIT_DIG = 5; // Digital detector declares
  localparam int unsigned LOSSL_BIT_ANA = 4; // Analog detector declares
  localparam int unsigned LOSSL_BIT_LOS = 1; // Channel loss of signal
  localparam int unsigned LOSSL_EV_DIG = 0; // Digital declare event
  localparam int unsigned LOSSL_EV_ANA = 1; // Analog declare event
  localparam int unsigned LOSSL_EV_LOS = 2; // Channel declare event
  localparam int unsigned LOSSL_CTRL_E3 = 0; // 1 selects E3 operation
  // ==========================================================
  // Reset values
  localparam logic [7:0] LOSSL_RST_MASK = 8'h00;
  localparam logic [7:0] LOSSL_RST_CTRL = 8'h00;
  localparam logic [7:0] LOSSL_RST_EVENT = 8'h00;
  // ==========================================================
  // Detector counts, in bit periods
  localparam int unsigned LOSSL_ZERO_RUN = 160; // Pulse-free periods to declare
  localparam int unsigned LOSSL_WIN = 64; // Density window length
  localparam int unsigned LOSSL_WIN_AW = 6; // Window address width
  localparam int unsigned LOSSL_DENS_PCT = 33; // Clear density, percent
  localparam int unsigned LOSSL_DENS_MIN = (LOSSL_WIN * LOSSL_DENS_PCT + 99) / 100;
endpackage

// ===== design/lossl_win_mem.sv
// Pulse history window memory, one bit per received bit period
`timescale 1ns/1ps
module lossl_win_mem
  import lossl_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_we, // Write strobe
  input wire logic [LOSSL_WIN_AW-1:0] i_addr, // Slot to read and overwrite
  input wire logic i_wdata, // New pulse flag
  output logic o_rdata // Old slot content, one cycle later
);
  // ==========================================================
  // Storage
  logic mem_r [LOSSL_WIN]; // No reset: the caller masks slots not yet filled
  logic rdata_r; // Registered read port

  // Read before write, so the old sample leaves as the new one enters
  always_ff @(posedge i_sys_clk) begin
    rdata_r <= mem_r[i_addr];
    if (i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = rdata_r;
endmodule

// ===== sim/lossl_line_model.sv
// Model of the incoming line: bit ticks with pulse flags, amplitude levels, E3 detector level
`timescale 1ns/1ps
module lossl_line_model (
  input wire logic i_sys_clk, // System clock
  output logic o_bit_tick, // High for one received bit period
  output logic o_pulse, // Pulse flag, meaningless between ticks
  output logic o_amp_low, // Amplitude below declare threshold
  output logic o_amp_ok, // Amplitude above clear threshold
  output logic o_g775_los // E3 detector declares
);
  logic pulse_r; // Pulse flag of the current tick
  logic junk_r; // Idle pattern, so no stale flag survives between ticks
  // =========================================
  // Quiet healthy line at time zero
  initial begin
    o_bit_tick = 1'b0;
    pulse_r = 1'b0;
    junk_r = 1'b0;
    o_amp_low = 1'b0;
    o_amp_ok = 1'b1;
    o_g775_los = 1'b0;
  end
  // Toggle every cycle so an unqualified pulse flag is never steady
  always @(posedge i_sys_clk) begin
    junk_r <= ~junk_r;
  end
  assign o_pulse = o_bit_tick ? pulse_r : junk_r;
  // =========================================
  // Send n back-to-back bit periods, all with the same pulse flag
  task automatic send(input int n, input logic p);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_bit_tick <= 1'b1;
      pulse_r <= p;
    end
    @(posedge i_sys_clk);
    o_bit_tick <= 1'b0;
  endtask
  // Amplitude levels; callers never raise both, the thresholds are apart
  task automatic set_amp(input logic low, input logic ok);
    @(posedge i_sys_clk);
    o_amp_low <= low;
    o_amp_ok <= ok;
  endtask
  // E3 detector level
  task automatic set_e3(input logic v);
    @(posedge i_sys_clk);
    o_g775_los <= v;
  endtask
endmodule

// ===== sim/lossl_tb_top.sv
// Self-checking bench of the line loss-of-signal status block
`timescale 1ns/1ps
module lossl_tb_top;
  import lossl_pkg::*;
  logic i_sys_clk = 1'b0; // 40 MHz clock
  logic i_sys_rst = 1'b1; // Reset, high at start
  logic tick, pulse, amp_low, amp_ok, g775; // Line pins from the model
  logic [7:0] i_addr = 8'h00; // Register address
  logic [7:0] i_wdata = 8'h00; // Register write data
  logic i_wr = 1'b0; // Write strobe
  logic i_rd = 1'b0; // Read strobe
  logic [7:0] o_rdata; // Read data
  logic o_los, o_irq; // Channel state and interrupt
  int bad_count = 0; // Mismatches
  int n_compared = 0; // Comparisons
  int cyc = 0; // Cycle count for the hang limit
  always #12.5 i_sys_clk = ~i_sys_clk;
  lossl_line_model lossl_line_model_i (.i_sys_clk(i_sys_clk), .o_bit_tick(tick), .o_pulse(pulse),
    .o_amp_low(amp_low), .o_amp_ok(amp_ok), .o_g775_los(g775));
  lossl_top lossl_top_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_bit_tick(tick), .i_pulse(pulse),
    .i_amp_low(amp_low), .i_amp_ok(amp_ok), .i_g775_los(g775), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_los(o_los), .o_irq(o_irq));
  // =========================================
  // Verdict, reached from the sequence end or the hang limit
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // =========================================
  // Bus cycles: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask
  // Let pin synchronisers and status registers settle
  task automatic settle();
    repeat (8) @(posedge i_sys_clk);
    #1;
  endtask
  // =========================================
  // Reset values, unmapped place, alarm writes ignored
  task automatic t_reset();
    rd_chk("alarm", LOSSL_OFF_ALARM, 8'h00);
    rd_chk("event", LOSSL_OFF_EVENT, LOSSL_RST_EVENT);
    rd_chk("mask", LOSSL_OFF_MASK, LOSSL_RST_MASK);
    rd_chk("ctrl", LOSSL_OFF_CTRL, LOSSL_RST_CTRL);
    wr(8'h10, 8'hFF);
    rd_chk("unmapped", 8'h10, 8'h00);
    wr(LOSSL_OFF_ALARM, 8'hFF);
    rd_chk("alarm ro", LOSSL_OFF_ALARM, 8'h00);
  endtask
  // Digital declare at exactly 160 pulse-free periods, clear at 22 of 64 pulses
  task automatic t_digital();
    lossl_line_model_i.send(159, 1'b0);
    settle();
    rd_chk("alarm 159", LOSSL_OFF_ALARM, 8'h00);
    lossl_line_model_i.send(1, 1'b0);
    settle();
    chk("los dig", {7'h00, o_los}, 8'h01);
    rd_chk("alarm 160", LOSSL_OFF_ALARM, 8'h22);
    wr(LOSSL_OFF_ALARM, 8'h00);
    rd_chk("alarm held", LOSSL_OFF_ALARM, 8'h22);
    lossl_line_model_i.send(LOSSL_DENS_MIN - 1, 1'b1);
    settle();
    rd_chk("alarm 21", LOSSL_OFF_ALARM, 8'h22);
    lossl_line_model_i.send(1, 1'b1);
    settle();
    rd_chk("alarm 22", LOSSL_OFF_ALARM, 8'h00);
    chk("los clear", {7'h00, o_los}, 8'h00);
    rd_chk("event dig", LOSSL_OFF_EVENT, 8'h05);
  endtask
  // Second outage: the earlier pulses must have slid out of the window
  task automatic t_window();
    lossl_line_model_i.send(LOSSL_ZERO_RUN, 1'b0);
    settle();
    rd_chk("alarm again", LOSSL_OFF_ALARM, 8'h22);
    lossl_line_model_i.send(LOSSL_DENS_MIN - 1, 1'b1);
    settle();
    rd_chk("alarm again 21", LOSSL_OFF_ALARM, 8'h22);
    lossl_line_model_i.send(1, 1'b1);
    settle();
    rd_chk("alarm again 22", LOSSL_OFF_ALARM, 8'h00);
  endtask
  // Analog hysteresis with interrupt masking and clearing
  task automatic t_analog_irq();
    wr(LOSSL_OFF_EVENT, 8'h07);
    rd_chk("event w1c", LOSSL_OFF_EVENT, 8'h00);
    lossl_line_model_i.set_amp(1'b1, 1'b0);
    settle();
    rd_chk("alarm ana", LOSSL_OFF_ALARM, 8'h12);
    chk("irq masked", {7'h00, o_irq}, 8'h00);
    rd_chk("event ana", LOSSL_OFF_EVENT, 8'h06);
    wr(LOSSL_OFF_MASK, 8'h02);
    settle();
    chk("irq on", {7'h00, o_irq}, 8'h01);
    rd_chk("mask", LOSSL_OFF_MASK, 8'h02);
    wr(LOSSL_OFF_EVENT, 8'h02);
    settle();
    chk("irq off", {7'h00, o_irq}, 8'h00);
    rd_chk("event left", LOSSL_OFF_EVENT, 8'h04);
    lossl_line_model_i.set_amp(1'b0, 1'b0);
    settle();
    rd_chk("alarm gap", LOSSL_OFF_ALARM, 8'h12);
    lossl_line_model_i.set_amp(1'b0, 1'b1);
    settle();
    rd_chk("alarm ok", LOSSL_OFF_ALARM, 8'h00);
    chk("los ok", {7'h00, o_los}, 8'h00);
  endtask
  // E3 mode: channel state follows the E3 detector, line detectors idle
  task automatic t_e3();
    wr(LOSSL_OFF_CTRL, 8'h01);
    rd_chk("ctrl", LOSSL_OFF_CTRL, 8'h01);
    lossl_line_model_i.set_amp(1'b1, 1'b0);
    settle();
    chk("los e3 amp", {7'h00, o_los}, 8'h00);
    lossl_line_model_i.set_e3(1'b1);
    settle();
    chk("los e3", {7'h00, o_los}, 8'h01);
    rd_chk("alarm e3", LOSSL_OFF_ALARM, 8'h02);
    lossl_line_model_i.set_e3(1'b0);
    settle();
    rd_chk("alarm e3 off", LOSSL_OFF_ALARM, 8'h00);
  endtask
  // =========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_digital();
    t_window();
    t_analog_irq();
    t_e3();
    close_out();
  end
endmodule
